// File: inc/alert_overtemp_signal_consts.vh
// Constants for the alert mask, extended resolution, configuration and overtemperature timer registers
//
// Behaviour
// - Mask bits 2, 3, 4 are writable and block the alert for fan one, two, three faults.
// - Mask bit 5 blocks fan four faults, or timer events when pin four senses overtemperature.
// - Mask bits 6 and 7 block alerts for diode faults on remote one and two.
// - Mask bit 1 concerns overtemperature, is read-only, and writes never change it.
// - First extended register shows 2.5 V low bits at 1:0, supply low bits at 5:4.
// - Second extended register shows remote one, local, remote two low bits at 3:2, 5:4, 7:6.
// - Reading an extended register freezes it and its high bytes until those are read.
// - Configuration bit 0 turns the second fan drive pin into the alert output.
// - Configuration bit 1 enables overtemperature monitoring on its pin when so configured.
// - Full_speed_on_overtemp bit forces all fans to full duty while overtemperature is asserted.
// - Fast bit makes fan speed measurements repeat every 250 ms instead of every second.
// - Configuration bits 4 to 7 enable continuous speed measurement on inputs one to four.
// - Status bit 0 sets when overtemperature asserts and clears when the register is read.
// - Status bits 7:1 read zero until 45.52 ms; then 8-bit count in 22.76 ms steps.
// - Limit register holds the allowed duration; exceeding it sets interrupt status bit 5.
// - A limit of zero raises the interrupt at once when overtemperature asserts.
`ifndef ALERT_OVERTEMP_SIGNAL_CONSTS_VH
`define ALERT_OVERTEMP_SIGNAL_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_ALERT_MASK_TWO 8'h75
`define IDX_EXT_RES_VOLTAGE 8'h76
`define IDX_EXT_RES_TEMPERATURE 8'h77
`define IDX_CONFIG_THREE 8'h78
`define IDX_OVERTEMP_STATUS 8'h79
`define IDX_DURATION_LIMIT 8'h7a
`define IDX_INT_STATUS_TWO 8'h42
`define IDX_HIGH_2V5 8'h20
`define IDX_HIGH_VCC 8'h21
`define IDX_HIGH_REMOTE_ONE 8'h22
`define IDX_HIGH_LOCAL 8'h23
`define IDX_HIGH_REMOTE_TWO 8'h24
`define IDX_PIN_SELECT 8'h90

// Reset values
`define RST_ALERT_MASK_TWO 8'h00
`define RST_CONFIG_THREE 8'h00
`define RST_DURATION_LIMIT 8'h00
`define RST_PIN_SELECT 8'h00

// Writable bits of the mask register
`define MASK_TWO_WRITABLE 8'hfc

// Field positions
`define BIT_OVERTEMP_MASK 1
`define BIT_FAN_FOUR_OR_TIMER 5
`define BIT_CFG_ALERT_PIN 0
`define BIT_CFG_OVERTEMP_EN 1
`define BIT_CFG_FULL_SPEED_ON_OVERTEMP 2
`define BIT_CFG_FAST 3
`define BIT_CFG_CONT_LO 4

// Timing: clock period and documented times in ns
`define CLK_PERIOD_NS 8
`define DURATION_STEP_NS 22760000
`define FAST_PERIOD_NS 250000000
`define SLOW_PERIOD_NS 1000000000
// Cycle counts are the times above over the clock period, sized to the 27-bit timer parameters
`define DURATION_STEP_CYCLES 27'd2845000
`define FAST_PERIOD_CYCLES 27'd31250000
`define SLOW_PERIOD_CYCLES 27'd125000000
// Steps (45.52 ms) before the duration count is shown
`define DURATION_SHOW_STEPS 8'h02
`define DURATION_MAX 8'hff

`endif

// File: rtl/alert_mask_overtemp_signal_timer_regs.v
// Alert mask, extended resolution, configuration three and overtemperature timer registers on AHB-Lite
`timescale 1ns/1ps
`include "alert_overtemp_signal_consts.vh"

module alert_mask_overtemp_signal_timer_regs #(
  parameter [26:0] STEP_CYCLES = `DURATION_STEP_CYCLES,
  parameter [26:0] FAST_CYCLES = `FAST_PERIOD_CYCLES,
  parameter [26:0] SLOW_CYCLES = `SLOW_PERIOD_CYCLES
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Converter results
  input wire [9:0] reading_2v5,
  input wire [9:0] reading_vcc,
  input wire [9:0] reading_remote_one,
  input wire [9:0] reading_local,
  input wire [9:0] reading_remote_two,
  input wire voltage_update,
  input wire temperature_update,
  // Fault events, one-cycle pulses
  input wire [3:0] fan_fault,
  input wire [1:0] diode_fault,
  // Pins
  input wire fan_speed_input_four,
  input wire fan_pwm_two,
  output wire fan_drive_output_two_out,
  output wire fan_drive_output_two_oe,
  // Fan control
  output wire force_full_speed,
  output wire [3:0] continuous_speed,
  output reg speed_measure_start,
  output wire overtemp_active,
  output wire irq
);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  reg [7:0] alert_mask_two;
  reg [7:0] config_three;
  reg [7:0] overtemp_duration_limit;
  reg [7:0] pin_select;
  reg [7:0] int_status_two;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: reads act in the address phase, writes in the data phase
  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] addr_idx = haddr[9:2];
  wire rd_take = addr_phase & ~hwrite;
  reg wr_pend;
  reg [7:0] wr_idx;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_idx <= addr_idx;
    end
  end

  wire [7:0] wdata = hwdata[7:0];
  wire rd_ext_v = rd_take & (addr_idx == `IDX_EXT_RES_VOLTAGE);
  wire rd_ext_t = rd_take & (addr_idx == `IDX_EXT_RES_TEMPERATURE);
  wire rd_hi_2v5 = rd_take & (addr_idx == `IDX_HIGH_2V5);
  wire rd_hi_vcc = rd_take & (addr_idx == `IDX_HIGH_VCC);
  wire rd_hi_r1 = rd_take & (addr_idx == `IDX_HIGH_REMOTE_ONE);
  wire rd_hi_loc = rd_take & (addr_idx == `IDX_HIGH_LOCAL);
  wire rd_hi_r2 = rd_take & (addr_idx == `IDX_HIGH_REMOTE_TWO);
  wire rd_status = rd_take & (addr_idx == `IDX_OVERTEMP_STATUS);
  wire rd_int = rd_take & (addr_idx == `IDX_INT_STATUS_TWO);

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_mask_two <= `RST_ALERT_MASK_TWO;
      config_three <= `RST_CONFIG_THREE;
      overtemp_duration_limit <= `RST_DURATION_LIMIT;
      pin_select <= `RST_PIN_SELECT;
    end else if (wr_pend) begin
      case (wr_idx)
        `IDX_ALERT_MASK_TWO: alert_mask_two <= wdata & `MASK_TWO_WRITABLE;
        `IDX_CONFIG_THREE: config_three <= wdata;
        `IDX_DURATION_LIMIT: overtemp_duration_limit <= wdata;
        `IDX_PIN_SELECT: pin_select <= {7'h00, wdata[0]};
        default: ;
      endcase
    end
  end

  assign continuous_speed = config_three[7:`BIT_CFG_CONT_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Result registers with read freeze
  reg [9:0] res_2v5, res_vcc, res_r1, res_loc, res_r2;
  reg frz_v, frz_t;
  reg [1:0] pend_v;
  reg [2:0] pend_t;
  wire [1:0] next_pend_v = pend_v & ~{rd_hi_vcc, rd_hi_2v5};
  wire [2:0] next_pend_t = pend_t & ~{rd_hi_r2, rd_hi_loc, rd_hi_r1};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frz_v <= 1'b0;
      frz_t <= 1'b0;
      pend_v <= 2'h0;
      pend_t <= 3'h0;
    end else begin
      // A second read of the low bits while frozen restarts the wait for high bytes
      if (rd_ext_v) begin
        frz_v <= 1'b1;
        pend_v <= 2'h3;
      end else if (frz_v) begin
        pend_v <= next_pend_v;
        frz_v <= |next_pend_v;
      end
      if (rd_ext_t) begin
        frz_t <= 1'b1;
        pend_t <= 3'h7;
      end else if (frz_t) begin
        pend_t <= next_pend_t;
        frz_t <= |next_pend_t;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_2v5 <= 10'h000;
      res_vcc <= 10'h000;
      res_r1 <= 10'h000;
      res_loc <= 10'h000;
      res_r2 <= 10'h000;
    end else begin
      if (voltage_update && !frz_v && !rd_ext_v) begin
        res_2v5 <= reading_2v5;
        res_vcc <= reading_vcc;
      end
      if (temperature_update && !frz_t && !rd_ext_t) begin
        res_r1 <= reading_remote_one;
        res_loc <= reading_local;
        res_r2 <= reading_remote_two;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overtemperature pin: three-stage synchroniser, change accepted when stages two and three agree
  reg sync1, sync2, sync3, pin_level;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      sync1 <= fan_speed_input_four;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        pin_level <= sync3;
    end
  end

  // Pin four is active low when it serves as the overtemperature input
  wire pin_is_overtemp_signal = pin_select[0];
  assign overtemp_active = pin_is_overtemp_signal & config_three[`BIT_CFG_OVERTEMP_EN] & ~pin_level;
  reg overtemp_prev;
  wire overtemp_rise = overtemp_active & ~overtemp_prev;
  assign force_full_speed = overtemp_active & config_three[`BIT_CFG_FULL_SPEED_ON_OVERTEMP];

  //////////////////////////////////////////////////////////////////////////////
  // Duration timer; the step divider restarts at each assertion so counts are aligned to it
  reg [26:0] step_cnt;
  reg [7:0] run_cnt;
  reg [7:0] stat_cnt;
  reg stat_flag;
  reg limit_fired;
  wire step_tick = overtemp_active & ~overtemp_rise & (step_cnt == STEP_CYCLES - 27'd1);
  wire [7:0] run_inc = (run_cnt == `DURATION_MAX) ? run_cnt : run_cnt + 8'h01;
  wire limit_hit = (overtemp_rise & (overtemp_duration_limit == 8'h00)) |
                   (step_tick & (run_inc > overtemp_duration_limit) & ~limit_fired);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overtemp_prev <= 1'b0;
      step_cnt <= 27'h0000000;
      run_cnt <= 8'h00;
      limit_fired <= 1'b0;
    end else begin
      overtemp_prev <= overtemp_active;
      if (!overtemp_active || overtemp_rise) begin
        step_cnt <= 27'h0000000;
        run_cnt <= 8'h00;
        limit_fired <= overtemp_rise & (overtemp_duration_limit == 8'h00);
      end else begin
        if (step_tick) begin
          step_cnt <= 27'h0000000;
          run_cnt <= run_inc;
        end else begin
          step_cnt <= step_cnt + 27'h0000001;
        end
        if (limit_hit)
          limit_fired <= 1'b1;
      end
    end
  end

  // Status: read clears, but a new assertion or step in the same cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_flag <= 1'b0;
      stat_cnt <= 8'h00;
    end else begin
      if (overtemp_rise)
        stat_flag <= 1'b1;
      else if (rd_status)
        stat_flag <= 1'b0;
      if (step_tick)
        stat_cnt <= run_inc;
      else if (rd_status)
        stat_cnt <= 8'h00;
    end
  end

  // Below two steps only the assertion flag shows
  wire [7:0] status_view = (stat_cnt >= `DURATION_SHOW_STEPS) ? stat_cnt : {7'h00, stat_flag};

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status two: same layout as the mask, sticky, cleared by read
  wire fan_four_event = pin_is_overtemp_signal ? limit_hit : fan_fault[3];
  wire [7:0] int_events = {diode_fault, fan_four_event, fan_fault[2:0], overtemp_rise, 1'b0};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      int_status_two <= 8'h00;
    else if (rd_int)
      int_status_two <= int_events;
    else
      int_status_two <= int_status_two | int_events;
  end

  assign irq = |(int_status_two & ~alert_mask_two);

  // Alert is open drain, pulled low only while an unmasked bit is set
  assign fan_drive_output_two_out = config_three[`BIT_CFG_ALERT_PIN] ? 1'b0 : fan_pwm_two;
  assign fan_drive_output_two_oe = config_three[`BIT_CFG_ALERT_PIN] ? irq : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Speed measurement period
  reg [26:0] meas_cnt;
  wire [26:0] meas_period = config_three[`BIT_CFG_FAST] ? FAST_CYCLES : SLOW_CYCLES;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_cnt <= 27'h0000000;
      speed_measure_start <= 1'b0;
    end else if (meas_cnt >= meas_period - 27'd1) begin
      // Switching to fast mid-period ends the long period at once if the count has already reached the fast period
      meas_cnt <= 27'h0000000;
      speed_measure_start <= 1'b1;
    end else begin
      meas_cnt <= meas_cnt + 27'h0000001;
      speed_measure_start <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, loaded at the address phase
  reg [7:0] rd_val;
  always @* begin
    case (addr_idx)
      `IDX_ALERT_MASK_TWO: rd_val = alert_mask_two;
      `IDX_EXT_RES_VOLTAGE: rd_val = {2'h0, res_vcc[1:0], 2'h0, res_2v5[1:0]};
      `IDX_EXT_RES_TEMPERATURE: rd_val = {res_r2[1:0], res_loc[1:0], res_r1[1:0], 2'h0};
      `IDX_CONFIG_THREE: rd_val = config_three;
      `IDX_OVERTEMP_STATUS: rd_val = status_view;
      `IDX_DURATION_LIMIT: rd_val = overtemp_duration_limit;
      `IDX_INT_STATUS_TWO: rd_val = int_status_two;
      `IDX_HIGH_2V5: rd_val = res_2v5[9:2];
      `IDX_HIGH_VCC: rd_val = res_vcc[9:2];
      `IDX_HIGH_REMOTE_ONE: rd_val = res_r1[9:2];
      `IDX_HIGH_LOCAL: rd_val = res_loc[9:2];
      `IDX_HIGH_REMOTE_TWO: rd_val = res_r2[9:2];
      `IDX_PIN_SELECT: rd_val = pin_select;
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_take)
      hrdata <= {24'h000000, rd_val};
  end

endmodule // alert_mask_overtemp_signal_timer_regs

// File: tb/alert_mask_overtemp_signal_timer_regs_tb_top.sv
// Self-checking testbench for the alert mask and overtemperature timer register slice
`timescale 1ns/1ps
`include "alert_overtemp_signal_consts.vh"
module alert_mask_overtemp_signal_timer_regs_tb_top;
  localparam int STEP = 8;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pin4 = 1, fan_drive_output_two = 0, vupd = 0, tupd = 0;
  reg [31:0] haddr = 0, hwdata = 0;
  reg [1:0] htrans = 0;
  reg [3:0] fan_fault = 0;
  reg [1:0] diode_fault = 0;
  reg [9:0] rdg [0:4];
  reg [9:0] old [0:4];
  wire [31:0] hrdata;
  wire hreadyout, hresp, pin_out, pin_oe, full, start, ot_act, irq;
  wire [3:0] cont;
  int mismatches = 0, tests_run = 0;
  reg [7:0] r;
  int n;

  alert_mask_overtemp_signal_timer_regs #(.STEP_CYCLES(27'd8), .FAST_CYCLES(27'd40), .SLOW_CYCLES(27'd160)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reading_2v5(rdg[0]), .reading_vcc(rdg[1]), .reading_remote_one(rdg[2]), .reading_local(rdg[3]),
    .reading_remote_two(rdg[4]), .voltage_update(vupd), .temperature_update(tupd), .fan_fault(fan_fault),
    .diode_fault(diode_fault), .fan_speed_input_four(pin4), .fan_pwm_two(fan_drive_output_two), .fan_drive_output_two_out(pin_out),
    .fan_drive_output_two_oe(pin_oe), .force_full_speed(full), .continuous_speed(cont),
    .speed_measure_start(start), .overtemp_active(ot_act), .irq(irq));

  always #4 hclk = ~hclk;
  always @(posedge hclk) fan_drive_output_two <= $urandom;

  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single word transfer; waits on hreadyout even though the slave answers at once
  task automatic bus(input [7:0] idx, input wr, input [7:0] wd, output [7:0] d);
    @(posedge hclk);
    hsel <= 1; haddr <= {22'h0, idx, 2'b00}; htrans <= 2'b10; hwrite <= wr;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 0; htrans <= 2'b00; hwdata <= {24'h0, wd};
    do @(posedge hclk); while (!hreadyout);
    d = hrdata[7:0];
  endtask

  task automatic wr(input [7:0] idx, input [7:0] wd);
    reg [7:0] d;
    bus(idx, 1'b1, wd, d);
  endtask

  task automatic rdc(input string name, input [7:0] idx, input [7:0] exp);
    reg [7:0] d;
    bus(idx, 1'b0, 8'h00, d);
    check(name, d, exp);
  endtask

  task automatic load();
    @(posedge hclk);
    for (int i = 0; i < 5; i++) rdg[i] <= $urandom;
    vupd <= 1; tupd <= 1;
    @(posedge hclk);
    vupd <= 0; tupd <= 0;
  endtask

  function automatic [7:0] ext_v();
    return {2'b00, rdg[1][1:0], 2'b00, rdg[0][1:0]};
  endfunction

  function automatic [7:0] ext_t();
    return {rdg[4][1:0], rdg[3][1:0], rdg[2][1:0], 2'b00};
  endfunction

  task automatic report_and_stop();
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    for (int i = 0; i < 5; i++) rdg[i] = 0;
    void'($urandom(32873));
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    rdc("mask2 reset", `IDX_ALERT_MASK_TWO, 8'h00);
    rdc("config3 reset", `IDX_CONFIG_THREE, 8'h00);
    rdc("status reset", `IDX_OVERTEMP_STATUS, 8'h00);
    rdc("limit reset", `IDX_DURATION_LIMIT, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 8'hff : (k == 1) ? 8'h03 : $urandom;
      wr(`IDX_ALERT_MASK_TWO, r);
      rdc("mask2", `IDX_ALERT_MASK_TWO, r & 8'hfc);
      wr(`IDX_CONFIG_THREE, r);
      rdc("config3", `IDX_CONFIG_THREE, r);
      check("continuous", cont, r[7:4]);
    end
    $display("test register access done");
    for (int f = 0; f < 2; f++) begin
      wr(`IDX_CONFIG_THREE, {4'h0, f[0], 3'h0});
      do @(posedge hclk); while (!start);
      n = 0;
      do begin @(posedge hclk); n++; end while (!start);
      check("measure period", n, f ? 40 : 160);
    end
    $display("test measure rate done");
    load();
    rdc("ext volt", `IDX_EXT_RES_VOLTAGE, ext_v());
    rdc("ext temp", `IDX_EXT_RES_TEMPERATURE, ext_t());
    for (int i = 0; i < 5; i++) old[i] = rdg[i];
    load();
    for (int i = 0; i < 5; i++) rdc("frozen high", `IDX_HIGH_2V5 + i, old[i][9:2]);
    load();
    rdc("ext volt new", `IDX_EXT_RES_VOLTAGE, ext_v());
    rdc("ext temp new", `IDX_EXT_RES_TEMPERATURE, ext_t());
    $display("test extended resolution done");
    wr(`IDX_CONFIG_THREE, 8'h01);
    for (int i = 0; i < 6; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(`IDX_ALERT_MASK_TWO, m ? (8'h04 << i) : 8'h00);
        @(posedge hclk);
        {diode_fault, fan_fault} <= 6'h01 << i;
        @(posedge hclk);
        {diode_fault, fan_fault} <= 6'h00;
        repeat (3) @(posedge hclk);
        check("irq on fault", irq, !m);
        check("alert pin", {pin_oe, pin_out}, {!m, 1'b0});
        rdc("int status", `IDX_INT_STATUS_TWO, 8'h04 << i);
      end
    end
    $display("test alert masks done");
    wr(`IDX_ALERT_MASK_TWO, 8'h00);
    wr(`IDX_PIN_SELECT, 8'h01);
    wr(`IDX_CONFIG_THREE, 8'h06);
    pin4 <= 0;
    repeat (10) @(posedge hclk);
    check("overtemp active", ot_act, 1'b1);
    check("full_speed_on_overtemp", full, 1'b1);
    rdc("status flag", `IDX_OVERTEMP_STATUS, 8'h01);
    rdc("zero limit", `IDX_INT_STATUS_TWO, 8'h22);
    wr(`IDX_CONFIG_THREE, 8'h02);
    // The write lands at the edge the task returns on; look one edge later
    @(posedge hclk);
    check("no full_speed_on_overtemp", full, 1'b0);
    pin4 <= 1;
    wr(`IDX_DURATION_LIMIT, 8'h05);
    rdc("limit", `IDX_DURATION_LIMIT, 8'h05);
    // Two full steps passed after the assertion before the pin release reached overtemp_active, so the count shows
    rdc("status count", `IDX_OVERTEMP_STATUS, 8'h02);
    rdc("status clear", `IDX_OVERTEMP_STATUS, 8'h00);
    pin4 <= 0;
    repeat (3 * STEP) @(posedge hclk);
    rdc("below limit", `IDX_INT_STATUS_TWO, 8'h02);
    repeat (6 * STEP) @(posedge hclk);
    rdc("above limit", `IDX_INT_STATUS_TWO, 8'h20);
    repeat (300 * STEP) @(posedge hclk);
    rdc("saturated count", `IDX_OVERTEMP_STATUS, 8'hff);
    pin4 <= 1;
    $display("test overtemperature timer done");
    report_and_stop();
  end
endmodule // alert_mask_overtemp_signal_timer_regs_tb_top

// File: tb/alert_overtemp_signal_checker.sv
// Concurrent checks on the ports of the alert mask and overtemperature timer register slice
`timescale 1ns/1ps
module alert_overtemp_signal_checker (
  // Clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Pins and fan control
  input wire fan_speed_input_four,
  input wire fan_pwm_two,
  input wire fan_drive_output_two_out,
  input wire fan_drive_output_two_oe,
  input wire force_full_speed,
  input wire [3:0] continuous_speed,
  input wire speed_measure_start,
  input wire overtemp_active,
  input wire irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_alert_pin_off: assert property (!fan_drive_output_two_oe |-> !irq && !fan_drive_output_two_out)
    else $error("alert pin released while alert pending");
  a_alert_pin_low: assert property (fan_drive_output_two_oe && !fan_drive_output_two_out &&
    fan_pwm_two |-> irq)
    else $error("fan drive pin low without alert");
  a_full_speed_on_overtemp_needs_overtemp: assert property (force_full_speed |-> overtemp_active)
    else $error("full speed without overtemperature");
  a_measure_pulse_gap: assert property (speed_measure_start |=> !speed_measure_start [*8])
    else $error("measure start pulses too close");
  a_overtemp_pin_low: assert property ($rose(overtemp_active) |->
    !$past(fan_speed_input_four) && !$past(fan_speed_input_four, 2))
    else $error("overtemperature active without low pin");
  a_continuous_by_write: assert property ($changed(continuous_speed) |->
    $past(hsel && htrans[1] && hwrite && hready, 2))
    else $error("continuous speed enables changed without write");
endmodule // alert_overtemp_signal_checker

bind alert_mask_overtemp_signal_timer_regs alert_overtemp_signal_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fan_speed_input_four(fan_speed_input_four), .fan_pwm_two(fan_pwm_two),
  .fan_drive_output_two_out(fan_drive_output_two_out), .fan_drive_output_two_oe(fan_drive_output_two_oe),
  .force_full_speed(force_full_speed), .continuous_speed(continuous_speed),
  .speed_measure_start(speed_measure_start), .overtemp_active(overtemp_active), .irq(irq));
